// File: logic/xdata_ext_sfr.sv
// xdata address extension, region decode and fast port registers
`default_nettype none

// Functional notes
// - pointer select picks first or second pointer
// - extension bytes apply only to external-data moves
// - pointer moves take top byte from paired register
// - indirect moves use top and middle byte registers
// - external data address is 24 bits wide
// - each fast port has data, owner, level registers
// - owner bit set: pin follows fast data bit
// - owner bit clear: pin follows hub data bit
// - pin level register is read-only live state
// - fast path covers subset; hub covers all ports
// - 0x000000-0x001FFF selects static RAM
// - 0x004000-0x0042FF selects clocking registers
// - 0x004400-0x0044FF selects interrupt controller
// - 0x005000-0x0051FF selects port control registers
// - 0x008000-0x008FFF selects EEPROM array
// - 0x010000-0x01FFFF selects interconnect configuration
// - 0x080000-0x081FFF selects ECC byte storage
// - 0x800000-0xFFFFFF goes to external memory port
module xdata_ext_sfr
  import xdata_ext_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  // special register access from the core
  input  wire logic [7:0]            i_sfr_addr,
  input  wire logic                  i_sfr_wr,
  input  wire logic                  i_sfr_rd,
  input  wire logic [7:0]            i_sfr_wdata,
  output logic      [7:0]            o_sfr_rdata,
  output logic                       o_sfr_ack,
  // external data move from the core
  input  wire logic                  i_xd_req,
  input  wire logic                  i_xd_we,
  input  wire logic                  i_xd_indirect,
  input  wire logic [15:0]           i_dptr0,
  input  wire logic [15:0]           i_dptr1,
  input  wire logic [7:0]            i_rx_low,
  input  wire logic [7:0]            i_xd_wdata,
  output logic      [7:0]            o_xd_rdata,
  output logic                       o_xd_done,
  output logic                       o_pointer_select,
  // decoded targets
  output logic      [XADDR_W-1:0]    o_tgt_addr,
  output logic      [NREGION-1:0]    o_tgt_sel,
  output logic                       o_tgt_we,
  output logic                       o_tgt_re,
  output logic      [7:0]            o_tgt_wdata,
  input  wire logic [NREGION*8-1:0]  i_tgt_rdata,
  // port pins
  input  wire logic [NPIN-1:0]       i_hub_port_output_data,
  input  wire logic [NPIN-1:0]       i_pin,
  output logic      [NPIN-1:0]       o_pin_out
);

  // index of a per-port register, with a hit flag on top
  function automatic logic [PORT_IDX_W:0] port_hit(
    input logic [7:0] addr,
    input logic [7:0] base
  );
    logic [7:0] diff;
    diff = addr - base;
    if (addr >= base && diff < 8'(NPORT))
      port_hit = {1'b1, diff[PORT_IDX_W-1:0]};
    else
      port_hit = '0;
  endfunction : port_hit

  // one-hot region of an xdata address, zero when unmapped
  function automatic logic [NREGION-1:0] region_of(
    input logic [XADDR_W-1:0] addr
  );
    region_of = '0;
    for (int r = 0; r < NREGION; r++)
      if (addr >= REGION_LO[r] && addr <= REGION_HI[r])
        region_of[r] = 1'b1;
  endfunction : region_of

  logic                      pointer_select;
  logic [7:0]                pointer0_high_byte;
  logic [7:0]                pointer1_high_byte;
  logic [7:0]                indirect_top_byte;
  logic [7:0]                indirect_middle_byte;
  logic [PIN_W-1:0]          port_fast_output_data   [NPORT];
  logic [PIN_W-1:0]          port_fast_owner_select  [NPORT];
  logic [NPIN-1:0]           pin_level;

  logic [PORT_IDX_W:0]       data_hit;
  logic [PORT_IDX_W:0]       level_hit;
  logic [PORT_IDX_W:0]       owner_hit;
  logic [7:0]                next_sfr_rdata;
  logic                      next_sfr_ack;
  logic [XADDR_W-1:0]        next_xd_addr;
  logic [NREGION-1:0]        next_sel;
  logic [7:0]                next_xd_rdata;
  logic                      pending_rd;
  logic                      pending_req;

  assign data_hit  = port_hit(i_sfr_addr, SFR_FAST_DATA_BASE);
  assign level_hit = port_hit(i_sfr_addr, SFR_PIN_LEVEL_BASE);
  assign owner_hit = port_hit(i_sfr_addr, SFR_OWNER_SEL_BASE);

  assign o_pointer_select = pointer_select;

  // address extension and pointer select registers
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      pointer_select       <= 1'b0;
      pointer0_high_byte   <= REG_RESET;
      pointer1_high_byte   <= REG_RESET;
      indirect_top_byte    <= REG_RESET;
      indirect_middle_byte <= REG_RESET;
    end
    else if (i_sfr_wr)
    begin
      unique case (i_sfr_addr)
        SFR_POINTER_SELECT:
          pointer_select <= i_sfr_wdata[POINTER_SELECT_BIT];
        SFR_POINTER0_HIGH:
          pointer0_high_byte <= i_sfr_wdata;
        SFR_POINTER1_HIGH:
          pointer1_high_byte <= i_sfr_wdata;
        SFR_INDIRECT_TOP:
          indirect_top_byte <= i_sfr_wdata;
        SFR_INDIRECT_MID:
          indirect_middle_byte <= i_sfr_wdata;
        default:
        begin
        end
      endcase
    end
  end

  // fast port data and owner registers; pin level has no write path
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      for (int k = 0; k < NPORT; k++)
      begin
        port_fast_output_data[k]  <= REG_RESET;
        port_fast_owner_select[k] <= REG_RESET;
      end
    end
    else if (i_sfr_wr)
    begin
      if (data_hit[PORT_IDX_W])
        port_fast_output_data[data_hit[PORT_IDX_W-1:0]] <= i_sfr_wdata;
      if (owner_hit[PORT_IDX_W])
        port_fast_owner_select[owner_hit[PORT_IDX_W-1:0]] <= i_sfr_wdata;
    end
  end

  // special register read mux
  always_comb
  begin
    next_sfr_rdata = SFR_UNMAPPED_RD;
    next_sfr_ack   = 1'b1;
    if (data_hit[PORT_IDX_W])
      next_sfr_rdata = port_fast_output_data[data_hit[PORT_IDX_W-1:0]];
    else if (owner_hit[PORT_IDX_W])
      next_sfr_rdata = port_fast_owner_select[owner_hit[PORT_IDX_W-1:0]];
    else if (level_hit[PORT_IDX_W])
      next_sfr_rdata = pin_level[level_hit[PORT_IDX_W-1:0]*PIN_W +: PIN_W];
    else
    begin
      unique case (i_sfr_addr)
        SFR_POINTER_SELECT:
          next_sfr_rdata = {7'h00, pointer_select};
        SFR_POINTER0_HIGH:
          next_sfr_rdata = pointer0_high_byte;
        SFR_POINTER1_HIGH:
          next_sfr_rdata = pointer1_high_byte;
        SFR_INDIRECT_TOP:
          next_sfr_rdata = indirect_top_byte;
        SFR_INDIRECT_MID:
          next_sfr_rdata = indirect_middle_byte;
        default:
          next_sfr_ack = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_sfr_rdata <= SFR_UNMAPPED_RD;
      o_sfr_ack   <= 1'b0;
    end
    else
    begin
      o_sfr_rdata <= i_sfr_rd ? next_sfr_rdata : SFR_UNMAPPED_RD;
      o_sfr_ack   <= (i_sfr_rd | i_sfr_wr) & next_sfr_ack;
    end
  end

  // 24-bit address formation, registered every cycle whether or not a move is requested
  always_comb
  begin
    if (i_xd_indirect)
      next_xd_addr = {indirect_top_byte, indirect_middle_byte, i_rx_low};
    else if (pointer_select)
      next_xd_addr = {pointer1_high_byte, i_dptr1};
    else
      next_xd_addr = {pointer0_high_byte, i_dptr0};
  end

  assign next_sel = region_of(next_xd_addr);

  // stage one: present address and strobes to the decoded target
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_tgt_addr  <= '0;
      o_tgt_sel   <= '0;
      o_tgt_we    <= 1'b0;
      o_tgt_re    <= 1'b0;
      o_tgt_wdata <= REG_RESET;
      pending_rd  <= 1'b0;
    end
    else
    begin
      o_tgt_addr  <= next_xd_addr;
      o_tgt_sel   <= i_xd_req ? next_sel : '0;
      o_tgt_we    <= i_xd_req & i_xd_we & (|next_sel);
      o_tgt_re    <= i_xd_req & ~i_xd_we & (|next_sel);
      o_tgt_wdata <= i_xd_wdata;
      pending_rd  <= i_xd_req & ~i_xd_we;
    end
  end

  // move in flight, so an unmapped move still completes
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      pending_req <= 1'b0;
    else
      pending_req <= i_xd_req;
  end

  // read return from the selected target
  always_comb
  begin
    next_xd_rdata = XDATA_UNMAPPED_RD;
    for (int r = 0; r < NREGION; r++)
      if (o_tgt_sel[r])
        next_xd_rdata = i_tgt_rdata[r*8 +: 8];
  end

  // stage two: answer to the core
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_xd_rdata <= XDATA_UNMAPPED_RD;
      o_xd_done  <= 1'b0;
    end
    else
    begin
      o_xd_done <= pending_req;
      if (pending_rd)
        o_xd_rdata <= next_xd_rdata;
    end
  end

  // pin sensing
  pin_level_sync #(
    .W (NPIN)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async (i_pin),
    .o_level (pin_level)
  );

  // per-pin owner choice between fast data and hub data
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_pin_out <= '0;
    else
    begin
      for (int k = 0; k < NPORT; k++)
        for (int b = 0; b < PIN_W; b++)
          o_pin_out[k*PIN_W+b] <= port_fast_owner_select[k][b]
            ? port_fast_output_data[k][b]
            : i_hub_port_output_data[k*PIN_W+b];
    end
  end

endmodule : xdata_ext_sfr

`default_nettype wire

// File: logic/xdata_ext_pkg.sv
// shared constants for the xdata address extension and fast port block
`default_nettype none

package xdata_ext_pkg;

  // fast port set: ports 0-6, 12 and 15, eight pins each
  localparam int NPORT = 9;
  localparam int PIN_W = 8;
  localparam int NPIN  = NPORT * PIN_W;
  localparam int PORT_IDX_W = 4;

  // core special register addresses
  localparam logic [7:0] SFR_POINTER_SELECT = 8'h86;
  localparam logic [7:0] SFR_POINTER0_HIGH  = 8'h93;
  localparam logic [7:0] SFR_POINTER1_HIGH  = 8'h95;
  localparam logic [7:0] SFR_INDIRECT_TOP   = 8'hEB;
  localparam logic [7:0] SFR_INDIRECT_MID   = 8'hA1;
  // per-port blocks, one address per port in list order 0-6, 12, 15
  localparam logic [7:0] SFR_FAST_DATA_BASE  = 8'hC0;
  localparam logic [7:0] SFR_PIN_LEVEL_BASE  = 8'hC9;
  localparam logic [7:0] SFR_OWNER_SEL_BASE  = 8'hD2;

  // field positions and reset values
  localparam int         POINTER_SELECT_BIT = 0;
  localparam logic [7:0] REG_RESET          = 8'h00;
  localparam logic [7:0] SFR_UNMAPPED_RD    = 8'h00;
  localparam logic [7:0] XDATA_UNMAPPED_RD  = 8'hFF;

  // xdata regions
  localparam int NREGION = 8;
  localparam int XADDR_W = 24;
  localparam int REGION_SRAM     = 0;
  localparam int REGION_CLOCKING = 1;
  localparam int REGION_INTCTRL  = 2;
  localparam int REGION_PORTCTRL = 3;
  localparam int REGION_EEPROM   = 4;
  localparam int REGION_DIGCFG   = 5;
  localparam int REGION_ECC      = 6;
  localparam int REGION_EXTMEM   = 7;

  localparam logic [XADDR_W-1:0] REGION_LO [NREGION] = '{
    24'h000000, 24'h004000, 24'h004400, 24'h005000,
    24'h008000, 24'h010000, 24'h080000, 24'h800000
  };
  localparam logic [XADDR_W-1:0] REGION_HI [NREGION] = '{
    24'h001FFF, 24'h0042FF, 24'h0044FF, 24'h0051FF,
    24'h008FFF, 24'h01FFFF, 24'h081FFF, 24'hFFFFFF
  };

endpackage : xdata_ext_pkg

`default_nettype wire

// File: logic/pin_level_sync.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none

module pin_level_sync #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] differ;

  assign differ = stage2 ^ stage3;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit moves only when the last two stages agree
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_level <= '0;
    else
      o_level <= (stage3 & ~differ) | (o_level & differ);
  end

endmodule : pin_level_sync

`default_nettype wire

// File: verification/xdata_ext_sfr_sva.sv
// checker for the xdata extension and fast port block
`default_nettype none
module xdata_ext_sfr_chk
  import xdata_ext_pkg::*;
(
  input wire logic               i_clk,
  input wire logic               i_srst,
  input wire logic [7:0]         i_sfr_addr,
  input wire logic               i_sfr_wr,
  input wire logic               i_sfr_rd,
  input wire logic [7:0]         o_sfr_rdata,
  input wire logic               o_sfr_ack,
  input wire logic               i_xd_req,
  input wire logic               i_xd_indirect,
  input wire logic [15:0]        i_dptr0,
  input wire logic [15:0]        i_dptr1,
  input wire logic [7:0]         i_rx_low,
  input wire logic               o_xd_done,
  input wire logic               o_pointer_select,
  input wire logic [XADDR_W-1:0] o_tgt_addr,
  input wire logic [NREGION-1:0] o_tgt_sel
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        mapped;
  logic [15:0] dsel;
  assign mapped = (i_sfr_addr inside {8'h86, 8'h93, 8'h95, 8'hEB, 8'hA1})
    || (i_sfr_addr >= 8'hC0 && i_sfr_addr <= 8'hDA);
  assign dsel = o_pointer_select ? i_dptr1 : i_dptr0;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  sequence s_req;
    i_xd_req ##1 1'b1;
  endsequence
  property p_ack;
    (i_sfr_rd || i_sfr_wr) |=> o_sfr_ack == $past(mapped);
  endproperty
  property p_rd0;
    !i_sfr_rd |=> o_sfr_rdata == 8'h00;
  endproperty
  property p_done;
    s_req |=> o_xd_done;
  endproperty
  property p_cause;
    o_xd_done |-> $past(i_xd_req, 2);
  endproperty
  property p_ptr;
    i_xd_req && !i_xd_indirect |=> o_tgt_addr[15:0] == $past(dsel);
  endproperty
  property p_ind;
    i_xd_req && i_xd_indirect |=> o_tgt_addr[7:0] == $past(i_rx_low);
  endproperty
  property p_sram;
    s_req |-> o_tgt_sel[0] == (o_tgt_addr <= 24'h001FFF);
  endproperty
  property p_ext;
    s_req |-> o_tgt_sel[7] == o_tgt_addr[23];
  endproperty
  a_ack: assert property (p_ack) else $error("bad ack");
  a_rd0: assert property (p_rd0) else $error("bad idle rdata");
  a_done: assert property (p_done) else $error("no done");
  a_cause: assert property (p_cause) else $error("stray done");
  a_ptr: assert property (p_ptr) else $error("bad pointer");
  a_ind: assert property (p_ind) else $error("bad low byte");
  a_sram: assert property (p_sram) else $error("bad sram sel");
  a_ext: assert property (p_ext) else $error("bad ext sel");
endmodule : xdata_ext_sfr_chk

bind xdata_ext_sfr xdata_ext_sfr_chk chk_u (.i_clk, .i_srst, .i_sfr_addr,
  .i_sfr_wr, .i_sfr_rd, .o_sfr_rdata, .o_sfr_ack, .i_xd_req, .i_xd_indirect,
  .i_dptr0, .i_dptr1, .i_rx_low, .o_xd_done, .o_pointer_select,
  .o_tgt_addr, .o_tgt_sel);
`default_nettype wire

// File: verification/xdata_target_model.sv
// decoded region targets answering xdata reads
`default_nettype none
module xdata_target_model
  import xdata_ext_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic [NREGION-1:0]   i_sel,
  output logic      [NREGION*8-1:0] o_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt = 8'h00;
  always_ff @(posedge i_clk)
    cnt <= cnt + 8'h01;
  // unselected regions show a moving pattern
  always_comb
    for (int r = 0; r < NREGION; r++)
      o_rdata[r*8+:8] = i_sel[r] ? 8'hA0 + 8'(r) : cnt ^ 8'(r);
endmodule : xdata_target_model
`default_nettype wire

// File: verification/xdata_address_ext_and_fast_port_sfr_tb_top.sv
// self-checking bench for the xdata extension and fast port block
`default_nettype none
module xdata_address_ext_and_fast_port_sfr_tb_top;
  import xdata_ext_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_srst, i_sfr_wr, i_sfr_rd, i_xd_req, i_xd_we;
  logic i_xd_indirect, o_sfr_ack, o_xd_done, o_pointer_select;
  logic o_tgt_we, o_tgt_re, psel;
  logic [7:0] i_sfr_addr, i_sfr_wdata, i_rx_low, i_xd_wdata;
  logic [7:0] o_sfr_rdata, o_xd_rdata, o_tgt_wdata, o_tgt_sel;
  logic [15:0] i_dptr0, i_dptr1;
  logic [23:0] o_tgt_addr;
  logic [NREGION*8-1:0] i_tgt_rdata;
  logic [NPIN-1:0] i_hub_port_output_data, i_pin, o_pin_out;
  logic [23:0] lo [8] = '{24'h000000, 24'h004000, 24'h004400, 24'h005000,
    24'h008000, 24'h010000, 24'h080000, 24'h800000};
  logic [23:0] hi [8] = '{24'h001FFF, 24'h0042FF, 24'h0044FF, 24'h0051FF,
    24'h008FFF, 24'h01FFFF, 24'h081FFF, 24'hFFFFFF};
  logic [7:0] ra [7] = '{8'h86, 8'h93, 8'h95, 8'hEB, 8'hA1, 8'hC0, 8'hD2};
  int n_mismatch = 0;
  int total_checks = 0;

  xdata_ext_sfr dut_u (.i_clk, .i_srst, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
    .i_sfr_wdata, .o_sfr_rdata, .o_sfr_ack, .i_xd_req, .i_xd_we,
    .i_xd_indirect, .i_dptr0, .i_dptr1, .i_rx_low, .i_xd_wdata, .o_xd_rdata,
    .o_xd_done, .o_pointer_select, .o_tgt_addr, .o_tgt_sel, .o_tgt_we,
    .o_tgt_re, .o_tgt_wdata, .i_tgt_rdata, .i_hub_port_output_data, .i_pin,
    .o_pin_out);
  xdata_target_model tgt_u (.i_clk, .i_sel(o_tgt_sel), .o_rdata(i_tgt_rdata));

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task automatic check(input string n, input logic [23:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // for reads d is the expected data
  task automatic sfr(input logic wr, input logic [7:0] a, d,
                     input logic ack);
    @(posedge i_clk);
    #1;
    i_sfr_wr = wr;
    i_sfr_rd = !wr;
    i_sfr_addr = a;
    i_sfr_wdata = d;
    @(posedge i_clk);
    #1;
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
    i_sfr_addr = ~a;
    check("sfr_ack", o_sfr_ack, ack);
    if (!wr)
      check("sfr_rdata", o_sfr_rdata, d);
  endtask : sfr

  // r is the expected region, 8 for none
  task automatic xd(input logic we, ind, input logic [23:0] a, input int r);
    if (ind)
    begin
      sfr(1'b1, 8'hEB, a[23:16], 1'b1);
      sfr(1'b1, 8'hA1, a[15:8], 1'b1);
    end
    @(posedge i_clk);
    #1;
    i_xd_req = 1'b1;
    i_xd_we = we;
    i_xd_indirect = ind;
    i_rx_low = ind ? a[7:0] : ~a[7:0];
    i_dptr0 = psel ? ~a[15:0] : a[15:0];
    i_dptr1 = psel ? a[15:0] : ~a[15:0];
    i_xd_wdata = a[7:0] ^ 8'h5A;
    @(posedge i_clk);
    #1;
    i_xd_req = 1'b0;
    i_xd_wdata = ~i_xd_wdata;
    check("tgt_addr", o_tgt_addr, a);
    check("tgt_sel", o_tgt_sel, (r < 8) ? 8'h01 << r : 8'h00);
    check("tgt_we", o_tgt_we, we && r < 8);
    check("tgt_re", o_tgt_re, !we && r < 8);
    if (we)
      check("tgt_wdata", o_tgt_wdata, a[7:0] ^ 8'h5A);
    @(posedge i_clk);
    #1;
    check("xd_done", o_xd_done, 1'b1);
    if (!we)
      check("xd_rdata", o_xd_rdata, (r < 8) ? 8'hA0 + r : 8'hFF);
  endtask : xd

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial
  begin
    #50000;
    n_mismatch++;
    close_out();
  end

  initial
  begin
    {i_sfr_wr, i_sfr_rd, i_xd_req, i_xd_we, i_xd_indirect, psel} = '0;
    {i_sfr_addr, i_sfr_wdata, i_rx_low, i_xd_wdata} = '0;
    {i_dptr0, i_dptr1, i_pin} = '0;
    i_hub_port_output_data = {NPORT{8'h3C}};
    i_srst = 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    i_srst = 1'b0;
    foreach (ra[j])
      sfr(1'b0, ra[j], 8'h00, 1'b1);
    sfr(1'b0, 8'h00, 8'h00, 1'b0);
    $display("test reset done");
    sfr(1'b1, 8'h93, 8'h08, 1'b1);
    sfr(1'b1, 8'h95, 8'h80, 1'b1);
    sfr(1'b1, 8'h86, 8'h01, 1'b1);
    psel = 1'b1;
    sfr(1'b0, 8'h86, 8'h01, 1'b1);
    xd(1'b0, 1'b0, 24'h801234, 7);
    check("pointer_select", o_pointer_select, 1'b1);
    sfr(1'b1, 8'h86, 8'h00, 1'b1);
    psel = 1'b0;
    xd(1'b0, 1'b0, 24'h080010, 6);
    xd(1'b1, 1'b0, 24'h081FFF, 6);
    $display("test pointer done");
    for (int r = 0; r < 8; r++)
    begin
      xd(1'b0, 1'b1, lo[r], r);
      xd(1'b1, 1'b1, hi[r], r);
    end
    xd(1'b0, 1'b1, 24'h002000, 8);
    xd(1'b1, 1'b1, 24'h004300, 8);
    xd(1'b0, 1'b1, 24'h7FFFFF, 8);
    $display("test region done");
    for (int k = 0; k < NPORT; k++)
      i_pin[k*8+:8] = 8'hC3 ^ 8'(k);
    repeat (6) @(posedge i_clk);
    for (int k = 0; k < NPORT; k++)
    begin
      sfr(1'b1, 8'hC0 + 8'(k), 8'hA5, 1'b1);
      sfr(1'b1, 8'hD2 + 8'(k), 8'h0F, 1'b1);
      sfr(1'b0, 8'hC0 + 8'(k), 8'hA5, 1'b1);
      sfr(1'b0, 8'hD2 + 8'(k), 8'h0F, 1'b1);
      @(posedge i_clk);
      #1;
      check("pin_out", o_pin_out[k*8+:8], 8'h35);
      i_hub_port_output_data[k*8+:8] = 8'hC3;
      @(posedge i_clk);
      #1;
      check("pin_out", o_pin_out[k*8+:8], 8'hC5);
      sfr(1'b0, 8'hC9 + 8'(k), 8'hC3 ^ 8'(k), 1'b1);
      sfr(1'b1, 8'hC9 + 8'(k), 8'hFF, 1'b1);
      sfr(1'b0, 8'hC9 + 8'(k), 8'hC3 ^ 8'(k), 1'b1);
    end
    $display("test port done");
    close_out();
  end
endmodule : xdata_address_ext_and_fast_port_sfr_tb_top
`default_nettype wire
